// file: include/txlis_pkg.sv
package txlis_pkg;

  // ----------------------------------------------------------------------
  // Sizing and reset values
  // ----------------------------------------------------------------------
  localparam int          NUM_CHAN        = 12;
  localparam logic        TX_ON_RESET     = 1'b1;
  localparam logic        EDGE_RISE_RESET = 1'b0;
  localparam logic [1:0]  SYNC_RESET      = 2'h0;
  localparam logic [1:0]  ZERO_CNT_RESET  = 2'h0;
  localparam logic [1:0]  ZERO_RUN_B3ZS   = 2'h2;
  localparam logic [1:0]  ZERO_RUN_HDB3   = 2'h3;
  localparam int          ENC_DELAY       = 4;

  // ----------------------------------------------------------------------
  // Channel line modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TXLIS_MODE_DS3,
    TXLIS_MODE_E3,
    TXLIS_MODE_STS1
  } txlis_mode_e;

  // Per-channel configuration as it arrives at the stage
  typedef struct packed {
    logic        tx_on;       // Per-channel transmitter on bit
    logic        dual_rail;   // 1: rails already encoded
    logic        fall_edge;   // 1: sample on falling clock edge
    txlis_mode_e mode;
  } txlis_cfg_s;

  // One symbol toward the pulse generator
  typedef struct packed {
    logic pos;
    logic neg;
  } txlis_sym_s;

  // Line driver pair, two signals each
  typedef struct packed {
    logic plus_o;
    logic plus_oe;
    logic minus_o;
    logic minus_oe;
  } txlis_drv_s;

endpackage

// file: core/txlis_delay_mem.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// Small shift memory holding the look-ahead window of the encoder
// ------------------------------------------------------------------------
module txlis_delay_mem #(
  parameter int DEPTH = 4
) (
  input  wire logic                clk_sys_in,  // System clock
  input  wire logic                rst_in,      // Async reset, high
  input  wire logic                shift_in,    // Advance one bit
  input  wire txlis_pkg::txlis_sym_s wr_in,     // Symbol entering
  input  wire txlis_pkg::txlis_sym_s fix_in,    // Rewrite of tail slot
  input  wire logic                fix_en_in,   // Apply rewrite
  input  wire logic                fix_near_in, // Rewrite one slot nearer
  output      txlis_pkg::txlis_sym_s rd_out     // Oldest symbol, registered
);

  typedef struct packed {
    txlis_pkg::txlis_sym_s [DEPTH-1:0] slot;
    txlis_pkg::txlis_sym_s             rd;
  } txlis_mem_s;

  txlis_mem_s state;
  txlis_mem_s next_state;

  always_comb
  begin
    next_state = state;
    if (shift_in)
    begin
      next_state.rd = state.slot[DEPTH-1];
      for (int i = DEPTH - 1; i > 0; i--)
      begin
        next_state.slot[i] = state.slot[i-1];
      end
      next_state.slot[0] = wr_in;
      // Substitution rewrites the bits that are already queued
      // Short runs put the pad two bits back, long runs three
      if (fix_en_in)
      begin
        if (fix_near_in)
        begin
          next_state.slot[DEPTH-2] = fix_in;
        end
        else
        begin
          next_state.slot[DEPTH-1] = fix_in;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rd_out = state.rd;

endmodule

// file: core/txlis_stage.sv
`timescale 1ns/10ps
// Operation
// - Transmitters come up powered on
// - Global enable low turns all transmitters off
// - Global enable high: per-channel bit decides
// - Transmit clock times the channel's section
// - Rails sampled with channel's own clock
// - Test pattern strobe follows transmit clock
// - Single rail: one bit latched per edge
// - Single rail: B3ZS for DS3/STS-1, HDB3 E3
// - Dual rail: positive pulse latched per edge
// - Dual rail bypasses encoder unchanged
// - Dual rail: negative pulse latched; else unused
// - Drivers high impedance while transmitter off
module txlis_stage #(
  parameter int NUM_CHAN = txlis_pkg::NUM_CHAN
) (
  input  wire logic                  clk_sys_in,            // System clock
  input  wire logic                  rst_in,                // Async reset
  input  wire logic                  global_tx_enable_pin,  // Global enable
  input  wire txlis_pkg::txlis_cfg_s [NUM_CHAN-1:0] cfg_in, // Channel setup
  input  wire logic [NUM_CHAN-1:0]   chan_transmit_clock_in,// Tx clocks
  input  wire logic [NUM_CHAN-1:0]   positive_rail_data_in, // Pos rail
  input  wire logic [NUM_CHAN-1:0]   negative_rail_data_in, // Neg rail
  output wire txlis_pkg::txlis_drv_s [NUM_CHAN-1:0] line_driver_out, // Drv
  output wire logic [NUM_CHAN-1:0]   prbs_tick_out          // Gen strobe
);

  // ----------------------------------------------------------------------
  // Global enable synchroniser
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync;
  } txlis_glb_s;

  txlis_glb_s glb;
  txlis_glb_s next_glb;

  always_comb
  begin
    next_glb      = glb;
    next_glb.sync = {glb.sync[0], global_tx_enable_pin};
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Pin is pulled high, so start in the powered-on state
      glb.sync <= {2{txlis_pkg::TX_ON_RESET}};
    end
    else
    begin
      glb <= next_glb;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel transmit section
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      typedef struct packed {
        logic [1:0]            clk_sync;
        logic [1:0]            pos_sync;
        logic [1:0]            neg_sync;
        logic [1:0]            cfg_sync;  // tx_on, fall_edge
        logic                  clk_prev;
        logic                  strobe;
        txlis_pkg::txlis_sym_s raw;
        logic [1:0]            zero_run;
        logic [1:0]            ones_parity;
        logic                  last_pol;
        logic                  tx_on;
        txlis_pkg::txlis_drv_s drv;
      } txlis_ch_s;

      txlis_ch_s st;
      txlis_ch_s next_st;

      txlis_pkg::txlis_sym_s enc_sym;
      txlis_pkg::txlis_sym_s fix_sym;
      txlis_pkg::txlis_sym_s mem_rd;
      logic                  fix_en;
      logic                  active_edge;
      logic                  clk_now;
      logic                  run_hit;
      logic                  fix_near;
      logic [1:0]            run_len;

      // Edge of the link clock as seen after two flops
      assign clk_now     = st.clk_sync[1];
      assign active_edge = st.cfg_sync[0]
                         ? (st.clk_prev & ~clk_now)
                         : (~st.clk_prev & clk_now);

      // B3ZS replaces 3 zeros, HDB3 replaces 4 zeros
      assign run_len = (cfg_in[ch].mode == txlis_pkg::TXLIS_MODE_E3)
                     ? txlis_pkg::ZERO_RUN_HDB3
                     : txlis_pkg::ZERO_RUN_B3ZS;
      assign fix_near = (run_len == txlis_pkg::ZERO_RUN_B3ZS);
      assign run_hit = ~cfg_in[ch].dual_rail & ~st.raw.pos
                     & (st.zero_run == run_len);

      always_comb
      begin
        next_st          = st;
        enc_sym          = '0;
        fix_sym          = '0;
        fix_en           = 1'b0;
        next_st.clk_sync = {st.clk_sync[0], chan_transmit_clock_in[ch]};
        next_st.pos_sync = {st.pos_sync[0], positive_rail_data_in[ch]};
        next_st.neg_sync = {st.neg_sync[0], negative_rail_data_in[ch]};
        next_st.cfg_sync = {cfg_in[ch].tx_on, cfg_in[ch].fall_edge};
        next_st.clk_prev = clk_now;
        next_st.strobe   = active_edge;

        if (active_edge)
        begin
          // Rails aligned with the clock, both latched on one edge
          next_st.raw.pos = st.pos_sync[1];
          next_st.raw.neg = cfg_in[ch].dual_rail
                          & st.neg_sync[1];
          if (cfg_in[ch].dual_rail)
          begin
            enc_sym = st.raw;
          end
          else if (st.raw.pos)
          begin
            enc_sym.pos          = ~st.last_pol;
            enc_sym.neg          = st.last_pol;
            next_st.last_pol     = ~st.last_pol;
            next_st.ones_parity  = st.ones_parity + 2'h1;
            next_st.zero_run     = txlis_pkg::ZERO_CNT_RESET;
          end
          else if (run_hit)
          begin
            // Violation on this bit, bipolar pad at run start if even
            enc_sym.pos = st.last_pol;
            enc_sym.neg = ~st.last_pol;
            if (~st.ones_parity[0])
            begin
              enc_sym.pos      = ~st.last_pol;
              enc_sym.neg      = st.last_pol;
              fix_sym.pos      = ~st.last_pol;
              fix_sym.neg      = st.last_pol;
              fix_en           = 1'b1;
              next_st.last_pol = ~st.last_pol;
            end
            next_st.ones_parity = txlis_pkg::ZERO_CNT_RESET;
            next_st.zero_run    = txlis_pkg::ZERO_CNT_RESET;
          end
          else
          begin
            next_st.zero_run = st.zero_run + 2'h1;
          end
        end

        // Global low overrides every channel bit
        next_st.tx_on = glb.sync[1] & st.cfg_sync[1];
        next_st.drv.plus_oe  = st.tx_on;
        next_st.drv.minus_oe = st.tx_on;
        next_st.drv.plus_o   = st.tx_on & mem_rd.pos;
        next_st.drv.minus_o  = st.tx_on & mem_rd.neg;
      end

      always_ff @(posedge clk_sys_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          st          <= '0;
          st.cfg_sync <= {txlis_pkg::TX_ON_RESET,
                          txlis_pkg::EDGE_RISE_RESET};
          st.tx_on    <= txlis_pkg::TX_ON_RESET;
          st.drv.plus_oe  <= txlis_pkg::TX_ON_RESET;
          st.drv.minus_oe <= txlis_pkg::TX_ON_RESET;
        end
        else
        begin
          st <= next_st;
        end
      end

      // Look-ahead queue; the HDB3 pad lands on the oldest zero slot
      txlis_delay_mem #(
        .DEPTH (txlis_pkg::ENC_DELAY)
      ) u_delay (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .shift_in   (active_edge),
        .wr_in      (enc_sym),
        .fix_in     (fix_sym),
        .fix_en_in  (fix_en),
        .fix_near_in(fix_near),
        .rd_out     (mem_rd)
      );

      assign line_driver_out[ch] = st.drv;
      assign prbs_tick_out[ch]   = st.strobe;
    end
  endgenerate

endmodule

// file: test/txlis_stage_chk.sv
`timescale 1ns/10ps
// --------
// Port checker
// --------
module txlis_stage_chk #(
  parameter int NUM_CHAN = txlis_pkg::NUM_CHAN
) (
  input wire logic                                 clk_sys_in,  // Clk
  input wire logic                                 rst_in,      // Rst
  input wire logic                                 global_tx_enable_pin,
  input wire txlis_pkg::txlis_cfg_s [NUM_CHAN-1:0] cfg_in,      // Cfg
  input wire logic [NUM_CHAN-1:0]                  chan_transmit_clock_in,
  input wire logic [NUM_CHAN-1:0]                  positive_rail_data_in,
  input wire logic [NUM_CHAN-1:0]                  negative_rail_data_in,
  input wire txlis_pkg::txlis_drv_s [NUM_CHAN-1:0] line_driver_out,
  input wire logic [NUM_CHAN-1:0]                  prbs_tick_out // Tick
);
  logic [NUM_CHAN-1:0]   oe;
  txlis_pkg::txlis_drv_s d0;
  logic                  k0;
  logic                  fe;
  assign d0 = line_driver_out[0];
  assign k0 = chan_transmit_clock_in[0];
  assign fe = cfg_in[0].fall_edge;
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      oe[i] = line_driver_out[i].plus_oe;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_reset_on;
    $fell(rst_in) |-> oe == '1;
  endproperty
  a_reset_on: assert property (p_reset_on) else $error("off at reset");
  property p_glob_off;
    (!global_tx_enable_pin)[*4] |=> oe == '0;
  endproperty
  a_glob_off: assert property (p_glob_off) else $error("on, pin low");
  property p_chan_on;
    (global_tx_enable_pin && cfg_in[0].tx_on)[*5] |=> d0.plus_oe && d0.minus_oe;
  endproperty
  a_chan_on: assert property (p_chan_on) else $error("chan off");
  property p_chan_off;
    (!cfg_in[0].tx_on)[*3] |=> !d0.plus_oe && !d0.minus_oe;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("chan on");
  property p_off_quiet;
    !d0.plus_oe |-> !d0.minus_oe && !d0.plus_o && !d0.minus_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drive off");
  property p_tick_edge;
    prbs_tick_out[0] |-> (k0 ^ fe) && !($past(k0, 6) ^ fe);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("tick edge");
  property p_edge_tick;
    $rose(k0) && !fe |-> ##[2:5] prbs_tick_out[0];
  endproperty
  a_edge_tick: assert property (p_edge_tick) else $error("no tick");
  property p_tick_one;
    prbs_tick_out[0] |=> !prbs_tick_out[0];
  endproperty
  a_tick_one: assert property (p_tick_one) else $error("long tick");
  property p_one_rail;
    !(d0.plus_o && d0.minus_o);
  endproperty
  a_one_rail: assert property (p_one_rail) else $error("both rails");
  c_tick: cover property (prbs_tick_out[0]);
  c_off: cover property (!d0.plus_oe);
  c_pulse: cover property (d0.plus_o ##1 !d0.plus_o);
endmodule

bind txlis_stage txlis_stage_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .clk_sys_in, .rst_in, .global_tx_enable_pin, .cfg_in,
  .chan_transmit_clock_in, .positive_rail_data_in, .negative_rail_data_in,
  .line_driver_out, .prbs_tick_out);

// file: test/txlis_src_model.sv
`timescale 1ns/10ps
// --------
// Framer side of the link
// --------
module txlis_src_model (
  output logic clk_out, // Link clock
  output logic pos_out, // Positive rail
  output logic neg_out  // Negative rail
);
  logic fe = 1'b0;
  initial
  begin
    clk_out = 1'b0;
    pos_out = 1'b0;
    neg_out = 1'b0;
  end
  // Clock stands between frames; stale rails flip so nothing leans on them
  task automatic idle(input logic f);
    #2;
    fe = f;
    clk_out = f;
    pos_out = ~pos_out;
    neg_out = ~neg_out;
  endtask
  // 160 ns bit in place of line rate; rails move 80 ns before the active edge
  // Every change lands on a falling system clock edge
  task automatic send(input logic p, input logic n);
    #2;
    pos_out = p;
    neg_out = n;
    #80 clk_out = ~fe;
    #76 clk_out = fe;
    #2;
  endtask
endmodule

// file: test/txlis_stage_bench.sv
`timescale 1ns/10ps
module txlis_stage_bench;
  localparam int N = txlis_pkg::NUM_CHAN;
  localparam int LAT = txlis_pkg::ENC_DELAY + 1;
  localparam logic [10:0] BITS = 11'h423;
  logic                          clk_sys_in = 1'b0;
  logic                          rst_in = 1'b1;
  logic                          glob = 1'b1;
  txlis_pkg::txlis_cfg_s [N-1:0] cfg;
  txlis_pkg::txlis_drv_s [N-1:0] drv;
  logic [N-1:0]                  tick;
  logic                          lk, lp, ln;
  int                            errors = 0;
  int                            cmp_count = 0;
  int                            ticks = 0;
  logic [1:0] b3 [11] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0,
                          2'h1, 2'h0, 2'h2};
  logic [1:0] hd [11] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0,
                          2'h0, 2'h2, 2'h1};
  txlis_stage u_dut (.clk_sys_in, .rst_in, .global_tx_enable_pin(glob),
    .cfg_in(cfg), .chan_transmit_clock_in({N{lk}}),
    .positive_rail_data_in({N{lp}}), .negative_rail_data_in({N{ln}}),
    .line_driver_out(drv), .prbs_tick_out(tick));
  txlis_src_model u_src (.clk_out(lk), .pos_out(lp), .neg_out(ln));
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
    if (tick[0] === 1'b1)
      ticks++;
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (!ok)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic t_enable();
    logic [N-1:0] on, ex;
    for (int i = 0; i < N; i++) on[i] = drv[i].plus_oe & drv[i].minus_oe;
    chk(on === '1, "off after reset");
    glob <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    for (int i = 0; i < N; i++) on[i] = |drv[i];
    chk(on === '0, "driving while pin low");
    glob <= 1'b1;
    cfg[3].tx_on <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    for (int i = 0; i < N; i++) on[i] = drv[i].plus_oe | drv[i].minus_oe;
    ex = '1;
    ex[3] = 1'b0;
    chk(on === ex, "per channel enable");
    cfg[3].tx_on <= 1'b1;
    $display("enable test done");
  endtask
  // Reset first so every stream starts from a positive first mark
  task automatic t_stream(input txlis_pkg::txlis_mode_e md, input logic dual,
                          input logic fe, input logic [1:0] ex [11]);
    logic [1:0] rec [11+LAT];
    logic [1:0] s;
    int         t0;
    @(posedge clk_sys_in);
    cfg <= {N{txlis_pkg::txlis_cfg_s'{1'b1, dual, fe, md}}};
    do_reset();
    u_src.idle(fe);
    repeat (8) @(posedge clk_sys_in);
    t0 = ticks;
    for (int i = 0; i < 11 + LAT; i++)
    begin
      s = i < 11 ? (dual ? ex[i] : {BITS[i], 1'b1}) : 2'h0;
      u_src.send(s[1], s[0]);
      rec[i] = {drv[0].plus_o, drv[0].minus_o};
    end
    for (int i = 0; i < 11; i++) chk(rec[i+LAT] === ex[i], "symbol");
    chk(ticks - t0 == 11 + LAT, "tick count");
    u_src.idle(fe);
    $display("stream test done");
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    end_of_test();
  end
  initial
  begin
    cfg = {N{txlis_pkg::txlis_cfg_s'{1'b1, 1'b0, 1'b0,
                                     txlis_pkg::TXLIS_MODE_DS3}}};
    do_reset();
    t_enable();
    t_stream(txlis_pkg::TXLIS_MODE_DS3, 1'b0, 1'b0, b3);
    t_stream(txlis_pkg::TXLIS_MODE_STS1, 1'b0, 1'b0, b3);
    t_stream(txlis_pkg::TXLIS_MODE_E3, 1'b0, 1'b0, hd);
    t_stream(txlis_pkg::TXLIS_MODE_DS3, 1'b1, 1'b0, b3);
    t_stream(txlis_pkg::TXLIS_MODE_E3, 1'b1, 1'b1, hd);
    end_of_test();
  end
endmodule
